/* File: core/vlpt_channel.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// (RULE_01) Setpoint is slope times temperature minus offset
// (RULE_02) Slope and offset settable, nominal 11.14, 4696.0
// (RULE_03) Trip when pressure at or below setpoint
// (RULE_04) Use second smallest of four channel functions
// (RULE_05) Two of four channel trips trip reactor
// (RULE_06) Shutdown bypass suppresses channel trip
// (RULE_07) Trip clears above setpoint plus hysteresis
// (RULE_08) Operator resets reactor trip, never self-restored
// (RULE_09) Pressure to trip within 185 ms
// (RULE_10) Temperature to trip within 425 ms
// (RULE_11) Settable values checked, out-of-range entries rejected
// (RULE_12) Temperature input spans 520 to 620 degrees
// (RULE_13) Pressure input spans 1700 to 2500 units
// (RULE_14) Computed values never clamped
// (RULE_15) Alarm contact opens on channel trip
// (RULE_16) Fixed-point math wide enough, no overflow
module vlpt_channel #(
  parameter int PRES_LAT_CYC = vlpt_pkg::PRES_LAT_CYC,
  parameter int TEMP_LAT_CYC = vlpt_pkg::TEMP_LAT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [vlpt_pkg::PRES_W-1:0] pressure_measured,
  input wire logic [vlpt_pkg::TEMP_W-1:0] hot_leg_temp_measured,
  input wire logic bypass_key,
  input wire logic breaker_reset,
  input wire logic [vlpt_pkg::PEERS*vlpt_pkg::MARGIN_W-1:0] peer_margin,
  input wire logic [vlpt_pkg::PEERS-1:0] peer_trip,
  input wire logic param_wr,
  input wire logic [vlpt_pkg::SLOPE_W-1:0] param_slope,
  input wire logic [vlpt_pkg::OFFS_W-1:0] param_offset,
  input wire logic [vlpt_pkg::HYST_W-1:0] param_hyst,
  output logic signed [vlpt_pkg::MARGIN_W-1:0] margin_out,
  output logic channel_trip,
  output logic alarm_contact_closed,
  output logic reactor_trip,
  output logic param_reject
);
  localparam int MW = vlpt_pkg::MARGIN_W;
  localparam int PW = vlpt_pkg::PEERS * MW;

  // ==========================================
  // Input synchronisers
  // ==========================================
  // Two stages for each measurement, peer, bypass and breaker reset pin; only stage two is read
  // (RULE_13) full pressure span
  logic [vlpt_pkg::PRES_W-1:0] pres_s1_r, pres_s2_r;
  // (RULE_12) full temperature span
  logic [vlpt_pkg::TEMP_W-1:0] temp_s1_r, temp_s2_r;
  logic [PW-1:0] peer_m_s1_r, peer_m_s2_r;
  logic [vlpt_pkg::PEERS-1:0] peer_t_s1_r, peer_t_s2_r;
  logic byp_s1_r, byp_s2_r;
  logic brst_s1_r, brst_s2_r;

  // Synchroniser registers, held while ce is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pres_s1_r <= '0;
      pres_s2_r <= '0;
      temp_s1_r <= '0;
      temp_s2_r <= '0;
      peer_m_s1_r <= '0;
      peer_m_s2_r <= '0;
      peer_t_s1_r <= '0;
      peer_t_s2_r <= '0;
      byp_s1_r <= 1'b0;
      byp_s2_r <= 1'b0;
      brst_s1_r <= 1'b0;
      brst_s2_r <= 1'b0;
    end else if (ce) begin
      pres_s1_r <= pressure_measured;
      pres_s2_r <= pres_s1_r;
      temp_s1_r <= hot_leg_temp_measured;
      temp_s2_r <= temp_s1_r;
      peer_m_s1_r <= peer_margin;
      peer_m_s2_r <= peer_m_s1_r;
      peer_t_s1_r <= peer_trip;
      peer_t_s2_r <= peer_t_s1_r;
      byp_s1_r <= bypass_key;
      byp_s2_r <= byp_s1_r;
      brst_s1_r <= breaker_reset;
      brst_s2_r <= brst_s1_r;
    end
  end

  // ==========================================
  // Settable constants
  // ==========================================
  logic [vlpt_pkg::SLOPE_W-1:0] slope_r, slope_nxt;
  logic [vlpt_pkg::OFFS_W-1:0] offset_r, offset_nxt;
  logic [vlpt_pkg::HYST_W-1:0] hyst_r, hyst_nxt;
  logic reject_r, reject_nxt;
  logic entry_ok;

  // Range check of one entry
  always_comb begin
    entry_ok = (param_slope >= vlpt_pkg::SLOPE_LO) && (param_slope <= vlpt_pkg::SLOPE_HI) &&
               (param_offset >= vlpt_pkg::OFFSET_LO) && (param_offset <= vlpt_pkg::OFFSET_HI) &&
               (param_hyst <= vlpt_pkg::HYST_HI);
  end

  // Next constants: whole entry loads or none of it does
  always_comb begin
    slope_nxt = slope_r;
    offset_nxt = offset_r;
    hyst_nxt = hyst_r;
    reject_nxt = 1'b0;
    // (RULE_11) range checked entry
    if (param_wr && entry_ok) begin
      // (RULE_02) settable slope, offset
      slope_nxt = param_slope;
      offset_nxt = param_offset;
      hyst_nxt = param_hyst;
    end else if (param_wr) begin
      // Out of range: keep old values, flag for one cycle
      reject_nxt = 1'b1;
    end
  end

  // Constant registers start at nominal values
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slope_r <= vlpt_pkg::SLOPE_NOM;
      offset_r <= vlpt_pkg::OFFSET_NOM;
      hyst_r <= vlpt_pkg::HYST_NOM;
      reject_r <= 1'b0;
    end else if (ce) begin
      slope_r <= slope_nxt;
      offset_r <= offset_nxt;
      hyst_r <= hyst_nxt;
      reject_r <= reject_nxt;
    end
  end

  // ==========================================
  // Own function signal
  // ==========================================
  logic signed [MW-1:0] margin_r, margin_nxt;

  // Margin is pressure minus setpoint, all at 1/1600 unit steps.
  // 36 bits hold every product over the full input and constant
  // ranges, and the result is kept unclamped.
  always_comb begin
    // (RULE_01) pressure minus variable setpoint
    // (RULE_16) wide signed arithmetic
    // (RULE_14) no clamp on result
    margin_nxt = $signed(MW'(pres_s2_r) * vlpt_pkg::DEC_SCALE
                         + MW'(offset_r) * vlpt_pkg::FRAC_SCALE
                         - MW'(slope_r) * MW'(temp_s2_r));
  end

  // Own margin register, also sent to the peers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      margin_r <= '0;
    end else if (ce) begin
      margin_r <= margin_nxt;
    end
  end

  // ==========================================
  // Selection, comparator and voting
  // ==========================================
  logic signed [MW-1:0] sel_comb;
  logic signed [MW-1:0] sel_r, sel_nxt;
  logic trip_r, trip_nxt;
  logic rtrip_r, rtrip_nxt;
  logic contact_r, contact_nxt;
  logic [2:0] votes;

  // (RULE_04) second smallest of four
  vlpt_second_min #(.W(MW)) u_min2 (
    .val_a(margin_r),
    .val_b(peer_m_s2_r[MW-1:0]),
    .val_c(peer_m_s2_r[2*MW-1:MW]),
    .val_d(peer_m_s2_r[3*MW-1:2*MW]),
    .second_min(sel_comb)
  );

  // Comparator with hysteresis, then two-of-four vote
  always_comb begin
    sel_nxt = sel_comb;
    votes = 3'(trip_r) + 3'(peer_t_s2_r[0]) + 3'(peer_t_s2_r[1]) + 3'(peer_t_s2_r[2]);
    if (byp_s2_r) begin
      // (RULE_06) bypass forces clear
      trip_nxt = 1'b0;
    end else if (trip_r) begin
      // (RULE_07) clear above hysteresis band
      trip_nxt = !(sel_r > $signed(MW'(hyst_r) * vlpt_pkg::DEC_SCALE));
    end else begin
      // (RULE_03) equal counts as trip
      trip_nxt = (sel_r <= $signed(MW'(0)));
    end
    // (RULE_15) contact opens on trip
    contact_nxt = !trip_r;
    // (RULE_05) two or more trips
    // (RULE_08) held until operator reset
    if (votes >= 3'(vlpt_pkg::VOTE_MIN)) begin
      rtrip_nxt = 1'b1;
    end else if (brst_s2_r) begin
      rtrip_nxt = 1'b0;
    end else begin
      rtrip_nxt = rtrip_r;
    end
  end

  // Decision registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_r <= '0;
      trip_r <= 1'b0;
      contact_r <= 1'b1;
      rtrip_r <= 1'b0;
    end else if (ce) begin
      sel_r <= sel_nxt;
      trip_r <= trip_nxt;
      contact_r <= contact_nxt;
      rtrip_r <= rtrip_nxt;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign margin_out = margin_r;
  assign channel_trip = trip_r;
  assign alarm_contact_closed = contact_r;
  assign reactor_trip = rtrip_r;
  assign param_reject = reject_r;

  // ==========================================
  // Checks
  // ==========================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_lat_pres_budget: assert property (vlpt_pkg::PIPE_CYC <= PRES_LAT_CYC) // RULE_09
    else $error("pressure path exceeds latency budget");
  a_lat_temp_budget: assert property (vlpt_pkg::PIPE_CYC <= TEMP_LAT_CYC) // RULE_10
    else $error("temperature path exceeds latency budget");
  a_margin_calc: assert property (ce && $past(ce) && $past(ce, 2) && $past(rst_n) && $past(rst_n, 2) |-> // RULE_01
    margin_r == $signed(MW'($past(pres_s1_r, 2)) * vlpt_pkg::DEC_SCALE + MW'($past(offset_r)) * vlpt_pkg::FRAC_SCALE
                        - MW'($past(slope_r)) * MW'($past(temp_s1_r, 2))))
    else $error("margin does not follow inputs");
  a_trip_at_equal: assert property (ce && !trip_r && !byp_s2_r && sel_r == 0 |=> trip_r) // RULE_03
    else $error("equal comparison did not trip");
  a_bypass_clears: assert property (ce && byp_s2_r |=> !trip_r) // RULE_06
    else $error("trip present under bypass");
  a_hyst_holds: assert property (ce && trip_r && !byp_s2_r && sel_r > 0 && // RULE_07
    sel_r <= $signed(MW'(hyst_r) * vlpt_pkg::DEC_SCALE) |=> trip_r)
    else $error("trip cleared inside hysteresis band");
  a_vote_trips: assert property (ce && votes >= 3'd2 |=> rtrip_r) // RULE_05
    else $error("two channel trips did not trip reactor");
  a_no_self_reset: assert property (rtrip_r && !brst_s2_r |=> rtrip_r) // RULE_08
    else $error("reactor trip restored without reset");
  a_reject_keeps: assert property (ce && param_wr && !entry_ok |=> reject_r && $stable(slope_r) && $stable(hyst_r)) // RULE_11
    else $error("bad entry not rejected");
  a_contact_open: assert property (ce && $past(ce) && $past(rst_n) && $past(trip_r) |-> !alarm_contact_closed) // RULE_15
    else $error("contact closed while tripped");
  a_sel_second: assert property (ce |=> sel_r == $past(sel_comb)) // RULE_04
    else $error("selected value lost");

  c_chan_trip: cover property (!trip_r ##1 trip_r);
  c_auto_clear: cover property (trip_r && !byp_s2_r ##1 !trip_r);
  c_reactor_trip: cover property (!rtrip_r ##1 rtrip_r);
  c_reject: cover property (reject_r);
endmodule
`default_nettype wire

/* File: common/vlpt_pkg.sv */
// ==========================================
// Fixed-point formats and widths
// ==========================================
package vlpt_pkg;
  // Fractional bits of temperature, pressure and hysteresis (1/16 unit steps)
  localparam int FRAC_BITS = 4;
  // Temperature width: 620 degrees in 1/16 steps fits in 14 bits
  localparam int TEMP_W = 14;
  // Pressure width: 2500 units in 1/16 steps fits in 16 bits
  localparam int PRES_W = 16;
  // Slope in hundredths of a pressure unit per degree
  localparam int SLOPE_W = 16;
  // Offset in hundredths of a pressure unit
  localparam int OFFS_W = 24;
  // Hysteresis in 1/16 pressure unit steps
  localparam int HYST_W = 16;
  // Signed margin width, in 1/1600 pressure unit steps
  localparam int MARGIN_W = 36;
  // Number of peer channels and of all channels
  localparam int PEERS = 3;
  localparam int CHANS = 4;
  // Channel trips needed to trip the reactor
  localparam int VOTE_MIN = 2;

  // ==========================================
  // Scaling and nominal constants
  // ==========================================
  // Constants carry two decimal digits
  localparam logic [MARGIN_W-1:0] DEC_SCALE = 36'h000000064;
  // Brings the offset from hundredths to the product's scale
  localparam logic [MARGIN_W-1:0] FRAC_SCALE = 36'h000000010;
  // Nominal slope 11.14 and offset 4696.0, both times 100
  localparam logic [SLOPE_W-1:0] SLOPE_NOM = 16'h045a;
  localparam logic [OFFS_W-1:0] OFFSET_NOM = 24'h072a60;
  // Nominal hysteresis of 10 units in 1/16 steps
  localparam logic [HYST_W-1:0] HYST_NOM = 16'h00a0;

  // ==========================================
  // Entry range limits
  // ==========================================
  localparam logic [SLOPE_W-1:0] SLOPE_LO = 16'h01f4;
  localparam logic [SLOPE_W-1:0] SLOPE_HI = 16'h07d0;
  localparam logic [OFFS_W-1:0] OFFSET_LO = 24'h000000;
  localparam logic [OFFS_W-1:0] OFFSET_HI = 24'h0dbba0;
  localparam logic [HYST_W-1:0] HYST_HI = 16'h0640;

  // ==========================================
  // Timing
  // ==========================================
  localparam int CLK_KHZ = 125000;
  localparam int PRES_LAT_MS = 185;
  localparam int TEMP_LAT_MS = 425;
  localparam int PRES_LAT_CYC = PRES_LAT_MS * CLK_KHZ;
  localparam int TEMP_LAT_CYC = TEMP_LAT_MS * CLK_KHZ;
  // Cycles from an input pin change to the channel trip flop
  localparam int PIPE_CYC = 5;
endpackage

/* File: core/vlpt_second_min.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Second-smallest of four signed values
// ==========================================
module vlpt_second_min #(
  parameter int W = vlpt_pkg::MARGIN_W
) (
  input wire logic signed [W-1:0] val_a,
  input wire logic signed [W-1:0] val_b,
  input wire logic signed [W-1:0] val_c,
  input wire logic signed [W-1:0] val_d,
  output logic signed [W-1:0] second_min
);
  // Smaller of two
  function automatic logic signed [W-1:0] smin(input logic signed [W-1:0] x, input logic signed [W-1:0] y);
    smin = (x < y) ? x : y;
  endfunction

  // Larger of two
  function automatic logic signed [W-1:0] smax(input logic signed [W-1:0] x, input logic signed [W-1:0] y);
    smax = (x < y) ? y : x;
  endfunction

  // Sort two pairs, then the second smallest is the smaller of the
  // larger low and the smaller high
  always_comb begin
    second_min = smin(smax(smin(val_a, val_b), smin(val_c, val_d)),
                      smin(smax(val_a, val_b), smax(val_c, val_d)));
  end
endmodule
`default_nettype wire

/* File: verification/vlpt_peer_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Peer channels and operator breaker reset
// ==========================================
module vlpt_peer_model (
  input wire logic mclk,
  input wire logic [107:0] cmd_margin,
  input wire logic [2:0] cmd_trip,
  input wire logic cmd_reset,
  output logic [107:0] peer_margin,
  output logic [2:0] peer_trip,
  output logic breaker_reset
);
  // Peers publish their function signals and trips once per cycle
  // peer outputs
  always_ff @(posedge mclk) begin
    peer_margin <= cmd_margin;
    peer_trip <= cmd_trip;
  end
  // Breakers come back only on an explicit operator command
  // explicit reset
  always_ff @(posedge mclk) begin
    breaker_reset <= cmd_reset;
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ==========================================
  // Stimulus and observed signals
  // ==========================================
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [15:0] p_in = 16'h7c40;
  logic [13:0] t_in = 14'h2580;
  logic bypass_key = 1'b1;
  logic param_wr = 1'b0;
  logic [15:0] slope_in = 16'h045a;
  logic [23:0] offs_in = 24'h072a60;
  logic [15:0] hyst_in = 16'h00a0;
  logic [107:0] cmd_margin = {3{36'h0004c4b40}};
  logic [2:0] cmd_trip = 3'h0;
  logic cmd_reset = 1'b0;
  logic [107:0] peer_margin;
  logic [2:0] peer_trip;
  logic breaker_reset;
  logic signed [35:0] margin_out;
  logic channel_trip, alarm_contact_closed, reactor_trip, param_reject;
  // Bench model state and counters
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h8c89;
  longint k = 1114, o = 469600, h = 160;
  longint pm[3] = '{5000000, 5000000, 5000000};
  bit e_trip = 0, e_rt = 0;
  int ts[6] = '{499, 500, 2000, 2001, 1114, 1114};
  int tof[6] = '{469600, 0, 900000, 469600, 900001, 469600};
  int th[6] = '{160, 1600, 0, 160, 160, 1601};
  int tp[4] = '{31808, 31968, 31969, 31809};

  always #4 mclk = ~mclk;

  vlpt_channel #(.PRES_LAT_CYC(16), .TEMP_LAT_CYC(16)) vlpt_channel_inst (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .pressure_measured(p_in), .hot_leg_temp_measured(t_in),
    .bypass_key(bypass_key), .breaker_reset(breaker_reset), .peer_margin(peer_margin),
    .peer_trip(peer_trip), .param_wr(param_wr), .param_slope(slope_in), .param_offset(offs_in),
    .param_hyst(hyst_in), .margin_out(margin_out), .channel_trip(channel_trip),
    .alarm_contact_closed(alarm_contact_closed), .reactor_trip(reactor_trip), .param_reject(param_reject));
  vlpt_peer_model vlpt_peer_model_inst (
    .mclk(mclk), .cmd_margin(cmd_margin), .cmd_trip(cmd_trip), .cmd_reset(cmd_reset),
    .peer_margin(peer_margin), .peer_trip(peer_trip), .breaker_reset(breaker_reset));

  // ==========================================
  // Helpers
  // ==========================================
  // Compare and count, report at once
  task automatic check(input string name, input logic signed [63:0] seen, input logic signed [63:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("Error %s expected %0d seen %0d", name, want, seen);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Fixed-seed random in 0..n-1
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction
  // Second smallest of four
  function automatic longint smin2(input longint a, input longint b, input longint c, input longint d);
    longint v[4];
    longint x;
    v = '{a, b, c, d};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (v[j] > v[j+1]) begin
          x = v[j];
          v[j] = v[j+1];
          v[j+1] = x;
        end
      end
    end
    return v[1];
  endfunction
  // Let one change pass the pipeline, then step the model and compare
  task automatic settle();
    longint m, sel;
    repeat (9) @(posedge mclk);
    #1;
    m = longint'(p_in) * 100 - k * longint'(t_in) + o * 16;
    sel = smin2(m, pm[0], pm[1], pm[2]);
    if (bypass_key) begin
      e_trip = 0;
    end else if (!e_trip && sel <= 0) begin
      e_trip = 1;
    end else if (e_trip && sel > h * 100) begin
      e_trip = 0;
    end
    if (int'(e_trip) + $countones(cmd_trip) >= 2) begin
      e_rt = 1;
    end else if (cmd_reset) begin
      e_rt = 0;
    end
    check("margin_out", margin_out, m);
    check("channel_trip", channel_trip, e_trip);
    check("alarm_contact_closed", alarm_contact_closed, !e_trip);
    check("reactor_trip", reactor_trip, e_rt);
  endtask
  // One parameter entry, judged on the following cycle
  task automatic pwrite(input int s, input int of, input int hy);
    bit rej;
    rej = !(s >= 500 && s <= 2000 && of <= 900000 && hy <= 1600);
    @(posedge mclk);
    param_wr <= 1'b1;
    slope_in <= s[15:0];
    offs_in <= of[23:0];
    hyst_in <= hy[15:0];
    @(posedge mclk);
    param_wr <= 1'b0;
    #1;
    check("param_reject", param_reject, rej);
    if (!rej) begin
      k = s;
      o = of;
      h = hy;
    end
    settle();
  endtask

  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (19) @(posedge mclk);
    #1;
    check("margin_out", margin_out, 0);
    check("reactor_trip", reactor_trip, 0);
    check("alarm_contact_closed", alarm_contact_closed, 1);
    @(posedge mclk);
    rst_n <= 1'b1;
    settle();
    // Equality trips, hysteresis holds then clears
    pm = '{-1000, 5000000, 5000000};
    @(posedge mclk);
    cmd_margin <= {36'h0004c4b40, 36'h0004c4b40, 36'hffffffc18};
    bypass_key <= 1'b0;
    settle();
    foreach (tp[i]) begin
      @(posedge mclk);
      p_in <= tp[i][15:0];
      settle();
    end
    // Clock enable low freezes every stage, then the change goes through
    @(posedge mclk);
    ce <= 1'b0;
    p_in <= 16'h6a40;
    repeat (10) @(posedge mclk);
    #1;
    check("margin_out", margin_out, 100);
    check("channel_trip", channel_trip, e_trip);
    @(posedge mclk);
    ce <= 1'b1;
    settle();
    // Entry limits on both sides
    foreach (ts[i]) begin
      pwrite(ts[i], tof[i], th[i]);
    end
    pwrite(1114, 469600, 160);
    // Random single changes
    for (int n = 0; n < 120; n++) begin
      @(posedge mclk);
      case (rnd(6))
        0: begin
          p_in <= 16'(27200 + rnd(12801));
          t_in <= 14'(8320 + rnd(1601));
        end
        1: begin
          foreach (pm[i]) begin
            pm[i] = longint'(rnd(4000000)) - 2000000;
          end
          cmd_margin <= {36'(pm[2]), 36'(pm[1]), 36'(pm[0])};
        end
        2: cmd_trip <= 3'(rnd(8));
        3: cmd_reset <= 1'(rnd(2));
        4: bypass_key <= 1'(rnd(4) == 0);
        default: pwrite(400 + rnd(1700), rnd(1000000), rnd(1800));
      endcase
      settle();
    end
    close_out();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
